// File: hw/ctd_crc32.sv
/*
 Byte-serial frame check generator and checker.
 Assumes init, enable and data share one clock.
*/
`timescale 1ns/100ps
module ctd_crc32 (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic init_in,
	input wire logic en_in,
	input wire logic [7:0] data_in,
	output logic [31:0] crc_out,
	output logic [31:0] next_out
);
	import ctd_pkg::*;

	typedef struct packed {
		logic [31:0] crc;
	} ctd_crc_type;

	ctd_crc_type s_q, s_d;

	// One byte, reflected, low bit first
	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// Init and a byte fold in one cycle
	always_comb begin
		s_d = s_q;
		if (init_in) begin
			s_d.crc = CRC_INIT;
		end
		if (en_in) begin
			s_d.crc = crc_byte(s_d.crc, data_in);
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_q <= '{crc: CRC_INIT};
		end else begin
			s_q <= s_d;
		end
	end

	assign crc_out = s_q.crc;
	assign next_out = s_d.crc;
endmodule

// File: hw/ctd_modem_receiver.sv
/*
 Modem receiver: parses each fragment alone, forwards TLV bytes unchanged,
 reports count, order and check result.
 Assumes the client takes a byte per cycle; the link never stalls.
*/
`timescale 1ns/100ps
module ctd_modem_receiver (
	input wire logic clk_in,
	input wire logic arst_n_in,
	ctd_link_if.modem link,
	output logic tlv_valid_out,
	output logic [7:0] tlv_data_out,
	output logic frag_start_out,
	output logic [7:0] frag_ccc_out,
	output logic [7:0] frag_nfrag_out,
	output logic [7:0] frag_seq_out,
	output logic frag_end_out,
	output logic frag_ok_out,
	output logic new_count_out,
	output logic dup_cfg_out
);
	import ctd_pkg::*;

	typedef struct packed {
		logic [4:0] idx;
		logic [15:0] rem;
		logic [1:0] ph;
		logic [7:0] tcnt;
		logic seen_cfg;
		logic have_ccc;
		logic [7:0] last_ccc;
		logic tv;
		logic [7:0] td;
		logic fs;
		logic [7:0] cc;
		logic [7:0] nf;
		logic [7:0] sq;
		logic fe;
		logic ok;
		logic nc;
		logic dup;
	} ctd_rx_type;

	ctd_rx_type s_q, s_d;
	logic take;
	logic [31:0] crc_next;

	assign take = link.valid;

	ctd_crc32 u_crc (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.init_in(take && (s_q.idx == 5'h0)),
		.en_in(take),
		.data_in(link.data),
		.crc_out(),
		.next_out(crc_next)
	);

	// ------------------------------------------------------------
	// Byte parser
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.tv = 1'b0;
		s_d.fs = 1'b0;
		s_d.fe = 1'b0;
		s_d.nc = 1'b0;
		s_d.dup = 1'b0;
		if (take) begin
			if (s_q.idx <= OFF_SEQ) begin
				s_d.idx = s_q.idx + 5'h01;
				if (s_q.idx == OFF_LEN_HI) s_d.rem[15:8] = link.data;
				if (s_q.idx == OFF_LEN_LO) s_d.rem[7:0] = link.data;
				if (s_q.idx == OFF_CCC) s_d.cc = link.data;
				if (s_q.idx == OFF_NFRAG) s_d.nf = link.data;
				if (s_q.idx == OFF_SEQ) begin
					s_d.sq = link.data;
					s_d.fs = 1'b1;
					s_d.rem = s_q.rem - LLC_TO_TLV;
					s_d.ph = 2'h0;
					s_d.have_ccc = 1'b1;
					s_d.last_ccc = s_q.cc;
					s_d.nc = !s_q.have_ccc || (s_q.cc != s_q.last_ccc);
					if (link.data == SEQ_FIRST) s_d.seen_cfg = 1'b0;
				end
			end else if (s_q.rem != 16'h0) begin
				s_d.tv = 1'b1;
				s_d.td = link.data;
				s_d.rem = s_q.rem - 16'h0001;
				unique case (s_q.ph)
					2'h0: begin
						if (link.data == TYPE_CONFIG) begin
							s_d.dup = s_q.seen_cfg;
							s_d.seen_cfg = 1'b1;
						end
						s_d.ph = 2'h1;
					end
					2'h1: begin
						s_d.tcnt = link.data;
						s_d.ph = (link.data == 8'h00) ? 2'h0 : 2'h2;
					end
					2'h2: begin
						s_d.tcnt = s_q.tcnt - 8'h01;
						if (s_q.tcnt == 8'h01) s_d.ph = 2'h0;
					end
					default: s_d.ph = 2'h0;
				endcase
			end
			if (link.last) begin
				s_d.idx = 5'h0;
				s_d.fe = 1'b1;
				s_d.ok = (crc_next == CRC_RESIDUE);
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Never stalls; no buffer
	assign link.ready = 1'b1;
	assign tlv_valid_out = s_q.tv;
	assign tlv_data_out = s_q.td;
	assign frag_start_out = s_q.fs;
	assign frag_ccc_out = s_q.cc;
	assign frag_nfrag_out = s_q.nf;
	assign frag_seq_out = s_q.sq;
	assign frag_end_out = s_q.fe;
	assign frag_ok_out = s_q.ok;
	assign new_count_out = s_q.nc;
	assign dup_cfg_out = s_q.dup;
endmodule

// File: hw/ctd_tunnel_agent.sv
/*
 Tunnel agent: TLV image loaded over AXI4-Lite, split at TLV boundaries,
 sent as checked fragments once per period on the byte link.
 Assumes software loads the image while status busy is low.
*/
// Added by the designer: the address map and register access over AXI4-Lite.
// How it works
// - At least one fragment every second
// - Whole descriptor repeated once per second
// - Config-only descriptor mode without tunnels
// - Table lists every tunnel on downstream
// - Fragments are management-style UI frames
// - Fragment at most 1522 bytes long
// - Any change bumps change count modulo
// - Same change count across all fragments
// - Fragment count is 8-bit, default one
// - Sequence starts at one, ends at count
// - Split only between whole TLVs
// - Each fragment self-contained with own check
// - TLVs changeable at run time, bumping count
// - Bump count after discontinuity events
// - Receiver drops old table on new count
// - Receiver never reinitialises on changes
// - Receiver forwards all TLVs unprocessed
// - Client skips unknown TLVs quietly
// - Vendor data type 43 with ID 8
// - No TLV length octet above 254
// - Mandatory sub only with parent; no repeats; repeats are still sent, the receiver flags config repeats
`timescale 1ns/100ps
module ctd_tunnel_agent #(
	parameter int TICK_CYC = ctd_pkg::TICK_CYC
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	ctd_link_if.agent link
);
	import ctd_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WALK = 3'b001,
		ST_HDR = 3'b010,
		ST_BODY = 3'b011,
		ST_FCS = 3'b100
	} ctd_ast_type;

	typedef struct packed {
		ctd_ast_type st;
		logic cnt_mode;
		logic [11:0] ptr;
		logic [11:0] fstart;
		logic [11:0] fend;
		logic [11:0] blen;
		logic [11:0] waddr;
		logic [7:0] nfrag;
		logic [7:0] seq;
		logic [7:0] ccc;
		logic [7:0] mcc;
		logic [4:0] hidx;
		logic [1:0] fidx;
		logic bump;
		logic [31:0] tmr;
		logic due;
		logic en;
		logic cfg_only;
		logic err_len;
		logic err_vendor_info_field;
		logic tx_v;
		logic tx_last;
		logic [7:0] tx_d;
		logic aw_ok;
		logic w_ok;
		logic [7:0] awa;
		logic [31:0] wd;
		logic [3:0] ws;
		logic bv;
		logic [1:0] br;
		logic rv;
		logic [31:0] rd;
		logic [1:0] rr;
	} ctd_agent_type;

	ctd_agent_type s_q, s_d;
	logic [7:0] mem [0:(1 << MEM_AW) - 1];
	logic mem_we;
	logic [31:0] crc_q;
	logic crc_init, crc_en;
	logic ld;
	logic [11:0] tl, eff_len;
	logic [7:0] cur_type, cur_len;
	logic fit, end_here;
	logic [15:0] flen;

	// Header byte at a given position of the fragment
	function automatic logic [7:0] hdr_byte(input logic [4:0] i, input logic [15:0] len,
		input logic [7:0] cc, input logic [7:0] nf, input logic [7:0] sq);
		logic [7:0] b;
		b = 8'h00;
		if (i < 5'h06) begin
			b = DEST_MAC[8'(47 - 8 * i) -: 8];
		end else if (i < OFF_LEN_HI) begin
			b = SRC_MAC[8'(95 - 8 * i) -: 8];
		end else if (i == OFF_LEN_HI) begin
			b = len[15:8];
		end else if (i == OFF_LEN_LO) begin
			b = len[7:0];
		end else if (i == OFF_LLC_CTRL) begin
			b = LLC_CTRL_UI;
		end else if (i == OFF_VERSION) begin
			b = MM_VERSION;
		end else if (i == OFF_TYPE) begin
			b = MM_TYPE;
		end else if (i == OFF_CCC) begin
			b = cc;
		end else if (i == OFF_NFRAG) begin
			b = nf;
		end else if (i == OFF_SEQ) begin
			b = sq;
		end
		return b;
	endfunction

	ctd_crc32 u_crc (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.init_in(crc_init),
		.en_in(crc_en),
		.data_in(s_d.tx_d),
		.crc_out(crc_q),
		.next_out()
	);

	// ------------------------------------------------------------
	// Walk helpers
	// ------------------------------------------------------------
	always_comb begin
		cur_type = mem[s_q.ptr[MEM_AW-1:0]];
		cur_len = mem[MEM_AW'(s_q.ptr + 12'h001)];
		tl = {4'h0, cur_len} + 12'h002;
		eff_len = s_q.cfg_only ? ({4'h0, mem[1]} + 12'h002) : s_q.blen;
		fit = (s_q.ptr - s_q.fstart + tl) <= FRAG_TLV_MAX;
		end_here = (s_q.ptr >= eff_len) || !fit;
		flen = LLC_TO_TLV + {4'h0, s_q.fend - s_q.fstart};
		ld = !s_q.tx_v || link.ready;
	end

	// ------------------------------------------------------------
	// Next state; hardware sets come after clears
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		mem_we = 1'b0;
		crc_init = 1'b0;
		crc_en = 1'b0;
		if (s_axi_awvalid_in && !s_q.aw_ok) begin
			s_d.aw_ok = 1'b1;
			s_d.awa = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && !s_q.w_ok) begin
			s_d.w_ok = 1'b1;
			s_d.wd = s_axi_wdata_in;
			s_d.ws = s_axi_wstrb_in;
		end
		if (s_q.bv && s_axi_bready_in) begin
			s_d.bv = 1'b0;
		end
		// Write when both halves held, no answer pending
		if (s_q.aw_ok && s_q.w_ok && !s_q.bv) begin
			s_d.aw_ok = 1'b0;
			s_d.w_ok = 1'b0;
			s_d.bv = 1'b1;
			s_d.br = RESP_OKAY;
			unique case (s_q.awa)
				REG_CTRL: begin
					if (s_q.ws[0]) begin
						s_d.en = s_q.wd[0];
						s_d.cfg_only = s_q.wd[1];
					end
				end
				REG_COMMIT: begin
					if (s_q.ws[0] && s_q.wd[0]) begin
						s_d.ccc = s_q.ccc + 8'h01;
					end
					if (s_q.ws[0] && s_q.wd[1]) begin
						s_d.bump = 1'b1;
					end
					if (s_q.ws[0] && s_q.wd[2]) begin
						s_d.err_len = 1'b0;
						s_d.err_vendor_info_field = 1'b0;
					end
				end
				REG_ADDR: s_d.waddr = s_q.wd[11:0];
				REG_DATA: begin
					mem_we = s_q.ws[0];
					s_d.waddr = s_q.waddr + 12'h001;
				end
				REG_LEN: s_d.blen = s_q.wd[11:0];
				REG_STATUS: ;
				default: s_d.br = RESP_SLVERR;
			endcase
		end
		if (s_q.rv && s_axi_rready_in) begin
			s_d.rv = 1'b0;
		end
		if (s_axi_arvalid_in && !s_q.rv) begin
			s_d.rv = 1'b1;
			s_d.rr = RESP_OKAY;
			unique case (s_axi_araddr_in)
				REG_CTRL: s_d.rd = {30'h0, s_q.cfg_only, s_q.en};
				REG_ADDR: s_d.rd = {20'h0, s_q.waddr};
				REG_LEN: s_d.rd = {20'h0, s_q.blen};
				REG_STATUS: s_d.rd = {13'h0, s_q.err_vendor_info_field, s_q.err_len,
					(s_q.st != ST_IDLE), s_q.nfrag, s_q.ccc};
				REG_COMMIT, REG_DATA: s_d.rd = 32'h0;
				default: begin
					s_d.rd = 32'h0;
					s_d.rr = RESP_SLVERR;
				end
			endcase
		end
		if (s_q.tmr == 32'(TICK_CYC - 1)) begin
			s_d.tmr = 32'h0;
			s_d.due = 1'b1;
		end else begin
			s_d.tmr = s_q.tmr + 32'h1;
		end
		if (ld) begin
			s_d.tx_v = 1'b0;
			s_d.tx_last = 1'b0;
		end
		unique case (s_q.st)
			ST_IDLE: begin
				if (s_q.en && s_q.due) begin
					s_d.due = 1'b0;
					s_d.st = ST_WALK;
					s_d.cnt_mode = 1'b1;
					s_d.ptr = 12'h0;
					s_d.fstart = 12'h0;
					s_d.nfrag = 8'h00;
					if (s_q.bump) begin
						s_d.ccc = s_d.ccc + 8'h01;
						s_d.bump = 1'b0;
					end
					// Keeps a same-cycle commit bump too
					s_d.mcc = s_d.ccc;
				end
			end
			ST_WALK: begin
				if (s_q.ptr < eff_len && cur_len == TLV_LEN_BAD) begin
					s_d.err_len = 1'b1;
					s_d.st = ST_IDLE;
				end else if (!end_here) begin
					// vendor data must lead with ID
					if (cur_type == TYPE_VENDOR &&
						mem[MEM_AW'(s_q.ptr + 12'h002)] != SUB_VENDOR_ID) begin
						s_d.err_vendor_info_field = 1'b1;
					end
					s_d.ptr = s_q.ptr + tl;
				end else if (s_q.cnt_mode) begin
					s_d.nfrag = s_q.nfrag + 8'h01;
					s_d.fstart = s_q.ptr;
					if (s_q.ptr >= eff_len) begin
						s_d.cnt_mode = 1'b0;
						s_d.ptr = 12'h0;
						s_d.fstart = 12'h0;
						s_d.seq = SEQ_FIRST;
					end
				end else begin
					s_d.fend = s_q.ptr;
					s_d.ptr = s_q.fstart;
					s_d.hidx = 5'h0;
					s_d.st = ST_HDR;
				end
			end
			ST_HDR: begin
				if (ld) begin
					s_d.tx_v = 1'b1;
					s_d.tx_d = hdr_byte(s_q.hidx, flen, s_q.mcc, s_q.nfrag, s_q.seq);
					crc_init = (s_q.hidx == 5'h0);
					crc_en = 1'b1;
					s_d.hidx = s_q.hidx + 5'h01;
					s_d.fidx = 2'h0;
					if (s_q.hidx == OFF_SEQ) begin
						s_d.st = (s_q.ptr == s_q.fend) ? ST_FCS : ST_BODY;
					end
				end
			end
			ST_BODY: begin
				if (ld) begin
					s_d.tx_v = 1'b1;
					s_d.tx_d = mem[s_q.ptr[MEM_AW-1:0]];
					crc_en = 1'b1;
					s_d.ptr = s_q.ptr + 12'h001;
					if (s_q.ptr + 12'h001 == s_q.fend) begin
						s_d.st = ST_FCS;
					end
				end
			end
			ST_FCS: begin
				if (ld) begin
					s_d.tx_v = 1'b1;
					s_d.tx_d = ~crc_q[8 * s_q.fidx +: 8];
					s_d.fidx = s_q.fidx + 2'h1;
					if (s_q.fidx == 2'h3) begin
						s_d.tx_last = 1'b1;
						if (s_q.seq == s_q.nfrag) begin
							s_d.st = ST_IDLE;
						end else begin
							s_d.seq = s_q.seq + 8'h01;
							s_d.fstart = s_q.ptr;
							s_d.st = ST_WALK;
						end
					end
				end
			end
			default: s_d.st = ST_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.nfrag <= NFRAG_RST;
			s_q.seq <= SEQ_FIRST;
		end else begin
			s_q <= s_d;
		end
	end

	// Image store, loaded by software, no reset
	always_ff @(posedge clk_in) begin
		if (mem_we) begin
			mem[s_q.waddr[MEM_AW-1:0]] <= s_q.wd[7:0];
		end
	end

	assign s_axi_awready_out = !s_q.aw_ok;
	assign s_axi_wready_out = !s_q.w_ok;
	assign s_axi_bvalid_out = s_q.bv;
	assign s_axi_bresp_out = s_q.br;
	assign s_axi_arready_out = !s_q.rv;
	assign s_axi_rvalid_out = s_q.rv;
	assign s_axi_rdata_out = s_q.rd;
	assign s_axi_rresp_out = s_q.rr;
	assign link.valid = s_q.tx_v;
	assign link.data = s_q.tx_d;
	assign link.last = s_q.tx_last;
endmodule

// File: shared/ctd_link_if.sv
/*
 Byte link from the tunnel agent to the modem receiver.
 Assumes both ends share clk_in.
*/
`timescale 1ns/100ps
interface ctd_link_if;
	logic [7:0] data;
	logic valid;
	logic last;
	logic ready;
	modport agent (output data, output valid, output last, input ready);
	modport modem (input data, input valid, input last, output ready);
endinterface

// File: shared/ctd_pkg.sv
/*
 Framer constants: timing, frame layout, TLV codes, register map, CRC.
 Assumes one 40 MHz clock and a byte-wide link.
*/
package ctd_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int PERIOD_S = 1;
	// Longest allowed interval
	localparam int TICK_CYC = CLK_HZ * PERIOD_S;

	// ------------------------------------------------------------
	// Frame layout
	// ------------------------------------------------------------
	localparam int FRAME_MAX = 1522;
	localparam int HDR_LEN = 23;
	localparam int FCS_LEN = 4;
	localparam logic [11:0] FRAG_TLV_MAX = 12'(FRAME_MAX - HDR_LEN - FCS_LEN);
	localparam logic [4:0] OFF_LEN_HI = 5'h0C;
	localparam logic [4:0] OFF_LEN_LO = 5'h0D;
	localparam logic [4:0] OFF_LLC_CTRL = 5'h10;
	localparam logic [4:0] OFF_VERSION = 5'h11;
	localparam logic [4:0] OFF_TYPE = 5'h12;
	localparam logic [4:0] OFF_CCC = 5'h14;
	localparam logic [4:0] OFF_NFRAG = 5'h15;
	localparam logic [4:0] OFF_SEQ = 5'h16;
	localparam logic [15:0] LLC_TO_TLV = 16'h0009;
	localparam logic [7:0] LLC_CTRL_UI = 8'h03;
	// Addresses and codes: arbitrary
	localparam logic [47:0] DEST_MAC = 48'h01E02F000001;
	localparam logic [47:0] SRC_MAC = 48'h020000000001;
	localparam logic [7:0] MM_VERSION = 8'h01;
	localparam logic [7:0] MM_TYPE = 8'h01;
	localparam logic [7:0] NFRAG_RST = 8'h01;
	localparam logic [7:0] SEQ_FIRST = 8'h01;

	// ------------------------------------------------------------
	// TLV values
	// ------------------------------------------------------------
	localparam logic [7:0] TLV_LEN_BAD = 8'hFF;
	localparam logic [7:0] TYPE_VENDOR = 8'h2B;
	localparam logic [7:0] SUB_VENDOR_ID = 8'h08;
	localparam logic [7:0] TYPE_CONFIG = 8'h33;
	localparam int MEM_AW = 11;

	// ------------------------------------------------------------
	// Register map and bus answers
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_COMMIT = 8'h04;
	localparam logic [7:0] REG_ADDR = 8'h08;
	localparam logic [7:0] REG_DATA = 8'h0C;
	localparam logic [7:0] REG_LEN = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Frame check
	// ------------------------------------------------------------
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
	localparam logic [31:0] CRC_POLY = 32'hEDB88320;
	localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
endpackage

// File: testbench/ctd_link_sva.sv
/*
 Checks on the agent-to-modem byte link.
 Assumes one clock and the package's frame layout.
*/
`timescale 1ns/100ps
module ctd_link_sva
	import ctd_pkg::*;
(
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic [7:0] data,
	input wire logic valid,
	input wire logic last,
	input wire logic ready
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	// ------------------------------------------------------------
	// Frame tracking
	// ------------------------------------------------------------
	typedef struct packed {
		logic [11:0] cnt;
		logic [15:0] len;
		logic [7:0] ccc, nf, seq, pseq, pnf, pccc;
		logic have;
	} ctd_trk_type;
	ctd_trk_type t_q, t_d;
	wire xfer = valid && ready;

	// Byte position, header fields; 12 bits cannot wrap
	always_comb begin
		t_d = t_q;
		if (xfer) begin
			t_d.cnt = last ? 12'h000 : t_q.cnt + 12'h001;
			if (t_q.cnt == 12'(OFF_LEN_HI)) t_d.len[15:8] = data;
			if (t_q.cnt == 12'(OFF_LEN_LO)) t_d.len[7:0] = data;
			if (t_q.cnt == 12'(OFF_CCC)) t_d.ccc = data;
			if (t_q.cnt == 12'(OFF_NFRAG)) t_d.nf = data;
			if (t_q.cnt == 12'(OFF_SEQ)) t_d.seq = data;
			if (last) begin
				t_d.pseq = t_q.seq;
				t_d.pnf = t_q.nf;
				t_d.pccc = t_q.ccc;
				t_d.have = 1'b1;
			end
		end
	end

	// Tracker register
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			t_q <= '0;
		end else begin
			t_q <= t_d;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence seq_byte_s;
		xfer && t_q.cnt == 12'(OFF_SEQ);
	endsequence
	sequence frame_end_s;
		xfer && last;
	endsequence

	dest_addr_a: assert property (
		xfer && t_q.cnt == 12'h000 |-> data == DEST_MAC[47:40]
	) else $error("Bad destination");
	llc_ctrl_a: assert property (
		xfer && t_q.cnt == 12'(OFF_LLC_CTRL) |-> data == LLC_CTRL_UI
	) else $error("Bad control byte");
	msg_type_a: assert property (
		xfer && t_q.cnt == 12'(OFF_TYPE) |-> data == MM_TYPE
	) else $error("Bad type");
	frame_len_a: assert property (
		frame_end_s |-> t_q.cnt < 12'(FRAME_MAX)
	) else $error("Frame too long");
	len_field_a: assert property (
		frame_end_s |-> 16'(t_q.cnt) == t_q.len + 16'h0011
	) else $error("Bad length field");
	seq_start_a: assert property (
		seq_byte_s ##0 (!t_q.have || t_q.pseq == t_q.pnf) |-> data == SEQ_FIRST
	) else $error("Bad first sequence");
	seq_step_a: assert property (
		seq_byte_s ##0 (t_q.have && t_q.pseq != t_q.pnf) |-> data == t_q.pseq + 8'h01
	) else $error("Bad sequence step");
	same_count_a: assert property (
		seq_byte_s ##0 (data != SEQ_FIRST) |-> t_q.ccc == t_q.pccc && t_q.nf == t_q.pnf
	) else $error("Count changed");
	nfrag_bound_a: assert property (
		seq_byte_s |-> t_q.nf != 8'h00 && data <= t_q.nf
	) else $error("Sequence too high");
endmodule

// File: testbench/tb_top.sv
/*
 Bench: AXI4-Lite into the agent, modem outputs watched.
 Assumes 40 MHz and a period shortened to TICK cycles.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tb_top;
	import ctd_pkg::*;
	localparam int TICK = 2000;
	logic clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, d;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, tv, fs, fe, fok, nc, dup;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] td, fc, fn, fq, ccc;
	logic [7:0] img[$], exp_q[$], rx_q[$];
	logic [24:0] hq[$];
	logic ok_q[$];
	logic [15:0] flen;
	int starts[$];
	bit bnd[int];
	int failures = 0, num_checks = 0, cyc = 0, pos = 0, dups = 0, fbytes = 0;

	// ------------------------------------------------------------
	// Ends, link and checker
	// ------------------------------------------------------------
	ctd_link_if link();
	ctd_tunnel_agent #(.TICK_CYC(TICK)) ctd_tunnel_agent_inst (.clk_in(clk_in),
		.arst_n_in(arst_n_in), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
		.s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
		.s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.link(link));
	ctd_modem_receiver ctd_modem_receiver_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.link(link), .tlv_valid_out(tv), .tlv_data_out(td), .frag_start_out(fs),
		.frag_ccc_out(fc), .frag_nfrag_out(fn), .frag_seq_out(fq), .frag_end_out(fe),
		.frag_ok_out(fok), .new_count_out(nc), .dup_cfg_out(dup));
	ctd_link_sva ctd_link_sva_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.data(link.data), .valid(link.valid), .last(link.last), .ready(link.ready));

	// Clock
	always #12.5 clk_in = ~clk_in;

	// Outputs as they stood before the edge
	always @(posedge clk_in) begin
		cyc++;
		if (tv) rx_q.push_back(td);
		if (tv) pos++;
		if (fs) hq.push_back({nc, fc, fn, fq});
		if (fs && fq == 8'h01) starts.push_back(cyc);
		if (fs && fq == 8'h01) pos = 0;
		if (fe) ok_q.push_back(fok);
		if (fe) `CHK("tlv boundary", 1, bnd.exists(pos))
		if (dup) dups++;
		if (link.valid && link.ready) begin
			if (fbytes == OFF_LEN_HI) flen[15:8] = link.data;
			if (fbytes == OFF_LEN_LO) flen[7:0] = link.data;
			fbytes++;
			if (link.last) begin
				`CHK("frame size", 32'(flen) + 18, fbytes)
				`CHK("frame limit", 1'b1, fbytes <= FRAME_MAX)
				fbytes = 0;
			end
		end
	end

	// ------------------------------------------------------------
	// Bus tasks; one idle edge after each
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] er = RESP_OKAY, input logic [3:0] s = 4'hF);
		bit aw, w, b = 0;
		int n = 0;
		logic [1:0] r;
		awaddr <= a;
		wdata <= v;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b && n < 100) begin
			@(negedge clk_in);
			aw = awvalid && awready;
			w = wvalid && wready;
			b = bvalid && bready;
			r = bresp;
			@(posedge clk_in);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			n++;
		end
		bready <= 1'b0;
		@(posedge clk_in);
		`CHK("write answer", 1, b)
		`CHK("write response", er, r)
	endtask

	task automatic rd(input logic [7:0] a, input logic [1:0] er = RESP_OKAY);
		bit ar, g = 0;
		int n = 0;
		logic [1:0] r;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!g && n < 100) begin
			@(negedge clk_in);
			ar = arvalid && arready;
			g = rvalid && rready;
			d = rdata;
			r = rresp;
			@(posedge clk_in);
			if (ar) arvalid <= 1'b0;
			n++;
		end
		rready <= 1'b0;
		@(posedge clk_in);
		`CHK("read answer", 1, g)
		`CHK("read response", er, r)
	endtask

	// Disable, wait until not busy
	task automatic stop;
		int n = 0;
		wr(REG_CTRL, 32'h0);
		d = 32'hFFFFFFFF;
		while (d[16] !== 1'b0 && n < 3000) begin
			rd(REG_STATUS);
			n++;
		end
		`CHK("busy cleared", 1'b0, d[16])
	endtask

	// One TLV; its boundaries kept for the split check
	function automatic void add_tlv(logic [7:0] t, logic [7:0] l, logic [7:0] b0 = 8'h00);
		bnd[img.size()] = 1;
		img.push_back(t);
		img.push_back(l);
		for (int i = 0; i < l; i++) img.push_back(i == 0 && b0 != 0 ? b0 : 8'($urandom));
		bnd[img.size()] = 1;
	endfunction

	task automatic load;
		stop();
		wr(REG_ADDR, 32'h0);
		foreach (img[i]) wr(REG_DATA, {24'h0, img[i]});
		wr(REG_LEN, 32'(img.size()));
	endtask

	// Enable and compare one whole message
	task automatic run_msg(input logic [31:0] ctrl, input logic nce);
		int n = 0;
		rx_q.delete();
		hq.delete();
		ok_q.delete();
		starts.delete();
		dups = 0;
		wr(REG_CTRL, ctrl);
		while (!(hq.size() > 0 && hq[$][7:0] == hq[$][15:8] && ok_q.size() == hq.size())
			&& n < 3 * TICK) begin
			@(posedge clk_in);
			n++;
		end
		`CHK("message done", 1'b1, n < 3 * TICK)
		`CHK("tlv count", exp_q.size(), rx_q.size())
		foreach (exp_q[i]) `CHK("tlv byte", exp_q[i], rx_q[i])
		foreach (hq[i]) begin
			`CHK("change count", ccc, hq[i][23:16])
			`CHK("new count", 1'(i == 0 && nce), hq[i][24])
			`CHK("fragment check", 1'b1, ok_q[i])
		end
		`CHK("fragments", 8'(hq.size()), hq[0][15:8])
	endtask

	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (70000) @(posedge clk_in);
		failures++;
		end_sim();
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'h55BD2193));
		repeat (5) @(posedge clk_in);
		arst_n_in <= 1'b1;
		@(posedge clk_in);
		rd(REG_STATUS);
		`CHK("status at reset", 19'h00100, d[18:0])
		rd(8'hFC, RESP_SLVERR);
		`CHK("unmapped read data", 32'h0, d)
		wr(8'hF0, 32'h1, RESP_SLVERR);
		// Multi-fragment image
		add_tlv(TYPE_CONFIG, 8'(4 + $urandom % 16));
		repeat (6) add_tlv(8'h32, 8'hFE);
		add_tlv(8'h17, 8'(1 + $urandom % 200));
		add_tlv(TYPE_VENDOR, 8'h05, SUB_VENDOR_ID);
		exp_q = img;
		load();
		wr(REG_COMMIT, 32'h1);
		ccc = 8'h01;
		rd(REG_STATUS);
		`CHK("count after change", ccc, d[7:0])
		run_msg(32'h1, 1'b1);
		repeat (2 * TICK) @(posedge clk_in);
		`CHK("repeated messages", 1'b1, starts.size() >= 3)
		for (int i = 1; i < starts.size(); i++) `CHK("gap", 1'b1, starts[i] - starts[i - 1] <= TICK)
		stop();
		// Failover bump
		wr(REG_COMMIT, 32'h2);
		ccc = 8'h02;
		run_msg(32'h1, 1'b1);
		stop();
		// Count wraps; lane zero off is ignored
		repeat (255) wr(REG_COMMIT, 32'h1);
		wr(REG_COMMIT, 32'h1, RESP_OKAY, 4'hE);
		ccc = ccc + 8'hFF;
		rd(REG_STATUS);
		`CHK("wrapped count", ccc, d[7:0])
		// Config-only mode
		img.delete();
		bnd.delete();
		add_tlv(TYPE_CONFIG, 8'h06);
		add_tlv(8'h32, 8'h0A);
		exp_q = img[0:7];
		load();
		run_msg(32'h3, 1'b1);
		`CHK("config only total", 8'h01, hq[0][15:8])
		stop();
		// Bad vendor id, repeated config
		img.delete();
		bnd.delete();
		add_tlv(TYPE_VENDOR, 8'h03, 8'h09);
		add_tlv(TYPE_CONFIG, 8'h02);
		add_tlv(TYPE_CONFIG, 8'h02);
		exp_q = img;
		load();
		run_msg(32'h1, 1'b0);
		rd(REG_STATUS);
		`CHK("vendor error", 1'b1, d[18])
		`CHK("repeated config", 1'b1, dups > 0)
		stop();
		// Length 255 aborts
		img = {8'h17, 8'hFF, 8'h00, 8'h00};
		load();
		hq.delete();
		wr(REG_CTRL, 32'h1);
		repeat (TICK + 500) @(posedge clk_in);
		`CHK("aborted frames", 0, hq.size())
		rd(REG_STATUS);
		`CHK("length error", 1'b1, d[17])
		stop();
		wr(REG_COMMIT, 32'h4);
		rd(REG_STATUS);
		`CHK("errors cleared", 2'b00, d[18:17])
		end_sim();
	end
endmodule
